//--- hw/serial_port_map.svh
/*
  Register offsets, bit positions, reset values and divisors of the serial port.
  Assumes an 8-bit register address space.
*/
`ifndef SERIAL_PORT_MAP_SVH
`define SERIAL_PORT_MAP_SVH

`define OFS_POWER_CONTROL 8'h87
`define OFS_SERIAL_CONTROL 8'h98
`define OFS_SERIAL_DATA 8'h99
`define OFS_BAUD_RELOAD 8'h9A
`define OFS_INTERRUPT_ENABLE 8'hA8
`define OFS_IRQ_STATUS 8'hC0
`define OFS_IRQ_MASK 8'hC1

`define RST_BYTE 8'h00
`define RST_EVENTS 3'h0

`define SC_MODE_BIT_ZERO 7
`define SC_MODE_BIT_ONE 6
`define SC_MULTIPROC 5
`define SC_RX_ENABLE 4
`define SC_TX_NINTH 3
`define SC_RX_NINTH 2
`define SC_TX_DONE 1
`define SC_RX_DONE 0
`define PC_BAUD_DOUBLE 7
`define PC_FE_SELECT 6
`define PC_RESERVED 5
`define IE_GLOBAL 7
`define IE_SERIAL 4
`define EV_TX 0
`define EV_RX 1
`define EV_FE 2

`define DIV_SHIFT 16'h000C
`define DIV_FIXED_SLOW 16'h0040
`define DIV_FIXED_FAST 16'h0020
`define DIV_VAR_STEP 16

`endif

//--- hw/serial_port_pkg.sv
/*
  Types of the serial port: engine states, register request and full state.
  Assumes nothing beyond the map header.
*/
package serial_port_pkg;
  typedef enum logic [1:0] {TX_IDLE, TX_SHIFT, TX_STOP} tx_state_type;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP, RX_SHIFT0} rx_state_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] wmask;
    logic wr;
    logic rd;
  } bus_req_type;

  typedef struct packed {
    logic [7:0] serial_control;
    logic fe;
    logic [7:0] power_control;
    logic [7:0] ie;
    logic [7:0] baud;
    logic [2:0] status;
    logic [2:0] mask;
    logic [7:0] rx_buf;
    tx_state_type tx_st;
    logic [15:0] tx_cnt;
    logic [3:0] tx_idx;
    logic [10:0] tx_sh;
    rx_state_type rx_st;
    logic [15:0] rx_cnt;
    logic [3:0] rx_idx;
    logic [8:0] rx_sh;
    logic rxd_prev;
    logic [7:0] rd_data;
    logic irq;
    logic txd;
    logic rxd_out;
    logic rxd_oe;
  } state_type;
endpackage

//--- hw/serial_port_control.sv
/*
  Serial port control: mode select, transmitter, receiver, framing error,
  interrupt flags, power control and interrupt enable registers.
  Assumes a register master on bus_req with read data one cycle later, a
  per-bit write mask for bit instructions, and pins synchronous to clk.
*/
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`include "serial_port_map.svh"

// Summary of operation
// - Invalid stop bit on a received frame sets the framing error flag.
// - Framing error stays set until software writes zero to it.
// - Control bit 7 maps to framing error if select is one, else mode bit zero.
// - Mode bits pick shift, 8-bit variable, 9-bit fixed or 9-bit variable rate.
// - Multiprocessor bit gates reception in modes 1-3; software keeps it clear in mode 0.
// - Reception happens only while the receive enable bit is one.
// - Modes 2 and 3 send the transmit ninth bit as data bit nine.
// - Modes 2 and 3 load the received ninth bit into bit 2.
// - Mode 1 stores the stop bit in bit 2; mode 0 leaves it unused.
// - Transmit flag sets after 8th bit in mode 0, else at stop start.
// - Mode 0 receive flag sets at the end of the eighth bit.
// - Control register resets to zero and each bit is writable alone.
// - Power control holds baud doubling at 7, select at 6, bit 5 reserved.
// - Serial interrupt reaches the CPU only with global and serial enables set.
module serial_port_control
  import serial_port_pkg::*;
#(
  parameter int VAR_STEP = `DIV_VAR_STEP
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire bus_req_type bus_req,
  input wire logic double_speed_mode,
  input wire logic rxd_in,
  output logic [7:0] rd_data,
  output logic irq,
  output logic txd,
  output logic rxd_out,
  output logic rxd_oe
);

  if (VAR_STEP < 2 || VAR_STEP > 255) begin : g_step_check
    $error("VAR_STEP must lie in 2..255");
  end

  state_type s_r;
  state_type s_nxt;

  logic [1:0] mode;
  logic [15:0] per;
  logic [15:0] half;
  logic [3:0] tx_bits;
  logic [3:0] rx_bits;
  logic wr_serial_control;
  logic tx_load;
  logic stop_eval;
  logic ev_tx;
  logic ev_rx;
  logic ev_fe;
  logic clk_low;
  logic [7:0] ctrl_merged;
  logic [7:0] msk_merged;

  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] w, input logic [7:0] m);
    merge = (old & ~m) | (w & m);
  endfunction

  assign mode = {s_r.serial_control[`SC_MODE_BIT_ZERO], s_r.serial_control[`SC_MODE_BIT_ONE]};
  assign half = per >> 1;
  assign wr_serial_control = bus_req.wr && bus_req.addr == `OFS_SERIAL_CONTROL;
  assign tx_load = bus_req.wr && bus_req.addr == `OFS_SERIAL_DATA && s_r.tx_st == TX_IDLE
    && s_r.rx_st != RX_SHIFT0;
  assign stop_eval = s_r.rx_st == RX_STOP && s_r.rx_cnt == 16'h0000 && s_r.serial_control[`SC_RX_ENABLE];

  // Bit time in clock cycles for the selected mode
  always_comb begin
    case (mode)
      2'b00: per = double_speed_mode ? (`DIV_SHIFT >> 1) : `DIV_SHIFT;
      2'b10: begin
        per = s_r.power_control[`PC_BAUD_DOUBLE] ? `DIV_FIXED_FAST : `DIV_FIXED_SLOW;
        if (double_speed_mode) begin
          per = per >> 1;
        end
      end
      default: per = 16'(({8'h00, s_r.baud} + 16'h0001) * 16'(VAR_STEP));
    endcase
    case (mode)
      2'b00: tx_bits = 4'h8;
      2'b01: tx_bits = 4'h9;
      default: tx_bits = 4'hA;
    endcase
    rx_bits = (mode == 2'b01) ? 4'h8 : 4'h9;
  end

  always_comb begin
    s_nxt = s_r;
    ev_tx = 1'b0;
    ev_rx = 1'b0;
    ev_fe = 1'b0;
    s_nxt.rxd_prev = rxd_in;
    ctrl_merged = merge(s_r.serial_control, bus_req.wdata, bus_req.wmask);
    msk_merged = merge({5'h00, s_r.mask}, bus_req.wdata, bus_req.wmask);

    // Software writes; each bit only where its mask bit is set
    if (wr_serial_control) begin
      s_nxt.serial_control[6:0] = ctrl_merged[6:0];
      if (bus_req.wmask[7]) begin
        if (s_r.power_control[`PC_FE_SELECT]) begin
          s_nxt.fe = bus_req.wdata[7];
        end else begin
          s_nxt.serial_control[7] = bus_req.wdata[7];
        end
      end
    end
    if (bus_req.wr) begin
      case (bus_req.addr)
        `OFS_POWER_CONTROL: begin
          s_nxt.power_control = merge(s_r.power_control, bus_req.wdata, bus_req.wmask);
          s_nxt.power_control[`PC_RESERVED] = 1'b0;
        end
        `OFS_INTERRUPT_ENABLE: s_nxt.ie = merge(s_r.ie, bus_req.wdata, bus_req.wmask);
        `OFS_BAUD_RELOAD: s_nxt.baud = merge(s_r.baud, bus_req.wdata, bus_req.wmask);
        `OFS_IRQ_STATUS: s_nxt.status = s_r.status & ~(bus_req.wdata[2:0] & bus_req.wmask[2:0]);
        `OFS_IRQ_MASK: s_nxt.mask = msk_merged[2:0];
        default: ;
      endcase
    end

    // Transmitter
    case (s_r.tx_st)
      TX_IDLE: begin
        if (tx_load) begin
          s_nxt.tx_st = TX_SHIFT;
          s_nxt.tx_cnt = per - 16'h0001;
          s_nxt.tx_idx = 4'h0;
          if (mode == 2'b00) begin
            s_nxt.tx_sh = {3'b111, bus_req.wdata};
          end else begin
            // Ninth position is the stop level in mode 1
            s_nxt.tx_sh = {1'b1, mode[1] ? s_r.serial_control[`SC_TX_NINTH] : 1'b1, bus_req.wdata, 1'b0};
          end
        end
      end
      TX_SHIFT: begin
        s_nxt.tx_cnt = s_r.tx_cnt - 16'h0001;
        if (s_r.tx_cnt == 16'h0000) begin
          s_nxt.tx_sh = {1'b1, s_r.tx_sh[10:1]};
          s_nxt.tx_idx = s_r.tx_idx + 4'h1;
          s_nxt.tx_cnt = per - 16'h0001;
          if (s_r.tx_idx + 4'h1 == tx_bits) begin
            ev_tx = 1'b1;
            s_nxt.tx_st = (mode == 2'b00) ? TX_IDLE : TX_STOP;
          end
        end
      end
      TX_STOP: begin
        s_nxt.tx_cnt = s_r.tx_cnt - 16'h0001;
        if (s_r.tx_cnt == 16'h0000) begin
          s_nxt.tx_st = TX_IDLE;
        end
      end
      default: s_nxt.tx_st = TX_IDLE;
    endcase

    // Receiver; dropping the enable abandons any frame in progress
    case (s_r.rx_st)
      RX_IDLE: begin
        if (s_r.serial_control[`SC_RX_ENABLE]) begin
          if (mode == 2'b00) begin
            // Shift mode receives only with the flag clear and the line free
            if (!s_r.serial_control[`SC_RX_DONE] && s_r.tx_st == TX_IDLE && !tx_load) begin
              s_nxt.rx_st = RX_SHIFT0;
              s_nxt.rx_cnt = per - 16'h0001;
              s_nxt.rx_idx = 4'h0;
            end
          end else if (s_r.rxd_prev && !rxd_in) begin
            s_nxt.rx_st = RX_START;
            s_nxt.rx_cnt = half - 16'h0001;
          end
        end
      end
      RX_START: begin
        s_nxt.rx_cnt = s_r.rx_cnt - 16'h0001;
        if (s_r.rx_cnt == 16'h0000) begin
          // A start bit gone high by mid-bit is a glitch
          s_nxt.rx_st = rxd_in ? RX_IDLE : RX_DATA;
          s_nxt.rx_cnt = per - 16'h0001;
          s_nxt.rx_idx = 4'h0;
        end
      end
      RX_DATA, RX_SHIFT0: begin
        s_nxt.rx_cnt = s_r.rx_cnt - 16'h0001;
        if (s_r.rx_cnt == 16'h0000) begin
          s_nxt.rx_sh = {rxd_in, s_r.rx_sh[8:1]};
          s_nxt.rx_idx = s_r.rx_idx + 4'h1;
          s_nxt.rx_cnt = per - 16'h0001;
          if (s_r.rx_st == RX_SHIFT0 && s_r.rx_idx == 4'h7) begin
            s_nxt.rx_st = RX_IDLE;
            s_nxt.rx_buf = s_nxt.rx_sh[8:1];
            ev_rx = 1'b1;
          end else if (s_r.rx_st == RX_DATA && s_r.rx_idx + 4'h1 == rx_bits) begin
            s_nxt.rx_st = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        s_nxt.rx_cnt = s_r.rx_cnt - 16'h0001;
        if (s_r.rx_cnt == 16'h0000) begin
          s_nxt.rx_st = RX_IDLE;
          ev_fe = !rxd_in;
          // Frame is kept only with the flag clear and the address filter met
          if (!s_r.serial_control[`SC_RX_DONE] && (!s_r.serial_control[`SC_MULTIPROC]
              || (mode == 2'b01 ? rxd_in : s_r.rx_sh[8]))) begin
            ev_rx = 1'b1;
            s_nxt.rx_buf = (mode == 2'b01) ? s_r.rx_sh[8:1] : s_r.rx_sh[7:0];
            s_nxt.serial_control[`SC_RX_NINTH] = (mode == 2'b01) ? rxd_in : s_r.rx_sh[8];
          end
        end
      end
      default: s_nxt.rx_st = RX_IDLE;
    endcase
    if (!s_r.serial_control[`SC_RX_ENABLE]) begin
      s_nxt.rx_st = RX_IDLE;
    end

    // Hardware sets win over a software clear in the same cycle
    if (ev_tx) begin
      s_nxt.serial_control[`SC_TX_DONE] = 1'b1;
    end
    if (ev_rx) begin
      s_nxt.serial_control[`SC_RX_DONE] = 1'b1;
    end
    if (ev_fe) begin
      s_nxt.fe = 1'b1;
    end
    s_nxt.status = s_nxt.status | {ev_fe, ev_rx, ev_tx};

    if (bus_req.rd) begin
      case (bus_req.addr)
        `OFS_SERIAL_CONTROL: s_nxt.rd_data = {s_r.power_control[`PC_FE_SELECT] ? s_r.fe : s_r.serial_control[7],
          s_r.serial_control[6:0]};
        `OFS_SERIAL_DATA: s_nxt.rd_data = s_r.rx_buf;
        `OFS_POWER_CONTROL: s_nxt.rd_data = s_r.power_control;
        `OFS_INTERRUPT_ENABLE: s_nxt.rd_data = s_r.ie;
        `OFS_BAUD_RELOAD: s_nxt.rd_data = s_r.baud;
        `OFS_IRQ_STATUS: s_nxt.rd_data = {5'h00, s_r.status};
        `OFS_IRQ_MASK: s_nxt.rd_data = {5'h00, s_r.mask};
        default: s_nxt.rd_data = `RST_BYTE;
      endcase
    end

    s_nxt.irq = s_nxt.ie[`IE_GLOBAL] && s_nxt.ie[`IE_SERIAL] && |(s_nxt.status & s_nxt.mask);

    // Mode 0: txd carries the shift clock, low in the first half of each bit
    clk_low = (s_nxt.tx_st == TX_SHIFT && mode == 2'b00 && s_nxt.tx_cnt >= half)
      || (s_nxt.rx_st == RX_SHIFT0 && s_nxt.rx_cnt >= half);
    if (mode == 2'b00) begin
      s_nxt.txd = !clk_low;
    end else begin
      s_nxt.txd = (s_nxt.tx_st == TX_SHIFT) ? s_nxt.tx_sh[0] : 1'b1;
    end
    s_nxt.rxd_oe = mode == 2'b00 && s_nxt.tx_st == TX_SHIFT;
    s_nxt.rxd_out = s_nxt.rxd_oe ? s_nxt.tx_sh[0] : 1'b1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
      s_r.tx_st <= TX_IDLE;
      s_r.rx_st <= RX_IDLE;
      s_r.rxd_prev <= 1'b1;
      s_r.txd <= 1'b1;
      s_r.rxd_out <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rd_data = s_r.rd_data;
  assign irq = s_r.irq;
  assign txd = s_r.txd;
  assign rxd_out = s_r.rxd_out;
  assign rxd_oe = s_r.rxd_oe;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_stop_bad;
    stop_eval ##0 !rxd_in;
  endsequence

  sequence s_tx_start9;
    tx_load ##0 mode[1];
  endsequence

  property p_fe_set;
    s_stop_bad |=> s_r.fe;
  endproperty
  a_fe_set: assert property (p_fe_set) else $error("framing error not set");

  property p_fe_sticky;
    s_r.fe && !(wr_serial_control && bus_req.wmask[7] && s_r.power_control[`PC_FE_SELECT]) |=> s_r.fe;
  endproperty
  a_fe_sticky: assert property (p_fe_sticky) else $error("framing error lost");

  property p_bit7_view;
    bus_req.rd && bus_req.addr == `OFS_SERIAL_CONTROL
      |=> rd_data[7] == ($past(s_r.power_control[`PC_FE_SELECT]) ? $past(s_r.fe) : $past(s_r.serial_control[7]));
  endproperty
  a_bit7_view: assert property (p_bit7_view) else $error("bit 7 view wrong");

  property p_mode2_rate;
    mode == 2'b10 && !s_r.power_control[`PC_BAUD_DOUBLE] && !double_speed_mode && s_r.tx_st == TX_SHIFT
      && s_r.tx_cnt == 16'h0000 |=> s_r.tx_cnt == 16'h003F;
  endproperty
  a_mode2_rate: assert property (p_mode2_rate) else $error("mode 2 bit time wrong");

  property p_rx_off;
    !s_r.serial_control[`SC_RX_ENABLE] |=> s_r.rx_st == RX_IDLE;
  endproperty
  a_rx_off: assert property (p_rx_off) else $error("receiving while disabled");

  property p_tx_ninth;
    s_tx_start9 |=> s_r.tx_sh[9] == $past(s_r.serial_control[`SC_TX_NINTH]);
  endproperty
  a_tx_ninth: assert property (p_tx_ninth) else $error("ninth bit not loaded");

  property p_rb8;
    stop_eval && ev_rx && mode[1] |=> s_r.serial_control[`SC_RX_NINTH] == $past(s_r.rx_sh[8]);
  endproperty
  a_rb8: assert property (p_rb8) else $error("received ninth bit wrong");

  property p_ti_stop;
    s_r.tx_st == TX_SHIFT && s_nxt.tx_st == TX_STOP |=> s_r.serial_control[`SC_TX_DONE] ##1 s_r.txd;
  endproperty
  a_ti_stop: assert property (p_ti_stop) else $error("tx flag not at stop");

  property p_ri_guard;
    stop_eval && ev_rx |-> !s_r.serial_control[`SC_RX_DONE];
  endproperty
  a_ri_guard: assert property (p_ri_guard) else $error("frame kept over full flag");

  property p_mp_gate;
    stop_eval && ev_rx && s_r.serial_control[`SC_MULTIPROC] |-> (mode[1] ? s_r.rx_sh[8] : rxd_in);
  endproperty
  a_mp_gate: assert property (p_mp_gate) else $error("address filter failed");

  property p_irq_gate;
    irq |-> s_r.ie[`IE_GLOBAL] && s_r.ie[`IE_SERIAL] && |(s_r.status & s_r.mask);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("interrupt not gated");

  property p_ti_shift;
    s_r.tx_st == TX_SHIFT && mode == 2'b00 && s_nxt.tx_st == TX_IDLE |=> s_r.serial_control[`SC_TX_DONE] && !rxd_oe;
  endproperty
  a_ti_shift: assert property (p_ti_shift) else $error("tx flag not after eighth bit");

  property p_ri_shift;
    s_r.rx_st == RX_SHIFT0 && s_r.rx_idx == 4'h7 && s_r.rx_cnt == 16'h0000 |=> s_r.serial_control[`SC_RX_DONE];
  endproperty
  a_ri_shift: assert property (p_ri_shift) else $error("rx flag not after eighth bit");

  // Only a software write may take a flag down
  property p_flags_kept;
    !wr_serial_control |=> (s_r.serial_control[`SC_TX_DONE:`SC_RX_DONE] & $past(s_r.serial_control[`SC_TX_DONE:`SC_RX_DONE]))
      == $past(s_r.serial_control[`SC_TX_DONE:`SC_RX_DONE]);
  endproperty
  a_flags_kept: assert property (p_flags_kept) else $error("flag cleared by hardware");

  property p_pwr_reserved;
    bus_req.wr && bus_req.addr == `OFS_POWER_CONTROL |=> !s_r.power_control[`PC_RESERVED];
  endproperty
  a_pwr_reserved: assert property (p_pwr_reserved) else $error("reserved bit stored");

endmodule

//--- dv/remote_station.sv
/*
  Remote serial station: sends frames on the receive line and decodes the transmit line.
  Assumes bit periods in clk cycles; the model drives the line high itself while idle.
*/
`timescale 1ns/1ps
module remote_station (
  input wire logic clk,
  input wire logic txd,
  output logic line
);
  initial line = 1'b1;

  // Stop level is a choice so that a broken stop bit can be sent on purpose
  task automatic send(input logic [8:0] d, input int n, input logic stp, input int p);
    line <= 1'b0;
    repeat (p) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      line <= d[i];
      repeat (p) @(posedge clk);
    end
    line <= stp;
    repeat (p) @(posedge clk);
    line <= 1'b1;
  endtask

  // Start width gives the bit time, so data bit 0 must be one
  task automatic grab(input int n, output int w, output logic [9:0] b);
    int k;
    k = 0;
    w = 0;
    b = '0;
    while (txd !== 1'b0 && k < 5000) begin
      @(negedge clk);
      k++;
    end
    while (txd === 1'b0 && w < 300) begin
      @(negedge clk);
      w++;
    end
    repeat (w / 2) @(negedge clk);
    for (int i = 0; i < n; i++) begin
      b[i] = txd;
      repeat (w) @(negedge clk);
    end
  endtask
endmodule

//--- dv/serial_port_control_bench.sv
/*
  Self-checking bench of the serial port control block.
  Assumes the remote station model and the register offsets of the map header.
*/
`timescale 1ns/1ps
`include "serial_port_map.svh"
module serial_port_control_bench;
  import serial_port_pkg::*;
  localparam logic [7:0] pc_o = `OFS_POWER_CONTROL;
  localparam logic [7:0] sc_o = `OFS_SERIAL_CONTROL;
  localparam logic [7:0] sd_o = `OFS_SERIAL_DATA;
  localparam logic [7:0] ie_o = `OFS_INTERRUPT_ENABLE;
  localparam logic [7:0] st_o = `OFS_IRQ_STATUS;
  localparam logic [7:0] mk_o = `OFS_IRQ_MASK;
  logic clk, rst_n, dsm, irq, txd, rxd_out, rxd_oe, line, rxd_in;
  logic oe_seen = 1'b0;
  logic [7:0] rd_data;
  logic [9:0] b;
  bus_req_type bus_req;
  int err_count = 0;
  int check_count = 0;
  int w;
  logic [7:0] tab [4][4] = '{'{8'hC8, 8'h00, 8'h00, 8'h04}, '{8'h88, 8'h00, 8'h00, 8'h40},
                             '{8'h88, 8'h80, 8'h00, 8'h20}, '{8'h88, 8'h80, 8'h01, 8'h10}};

  // Shared pin: whoever enables its driver owns the level
  assign rxd_in = rxd_oe ? rxd_out : line;
  always @(posedge clk) if (rxd_oe === 1'b1) oe_seen <= 1'b1;
  logic [7:0] sh0 = 8'h00;
  // Mode 0 data is steady while the shift clock rises mid-bit
  always @(posedge txd) if (rxd_oe === 1'b1) sh0 <= {rxd_out, sh0[7:1]};

  serial_port_control #(.VAR_STEP(4)) i_dut (.clk(clk), .rst_n(rst_n), .bus_req(bus_req),
    .double_speed_mode(dsm), .rxd_in(rxd_in), .rd_data(rd_data), .irq(irq), .txd(txd),
    .rxd_out(rxd_out), .rxd_oe(rxd_oe));
  remote_station i_remote (.clk(clk), .txd(txd), .line(line));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // Idle cycle after each access keeps a strobe from being set and cleared in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [7:0] m = 8'hFF);
    bus_req <= '{a, d, m, 1'b1, 1'b0};
    @(posedge clk);
    bus_req.wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    bus_req <= '{a, 8'h00, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    bus_req.rd <= 1'b0;
    @(negedge clk);
    d = rd_data;
    @(posedge clk);
  endtask

  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk(d, e);
  endtask

  task automatic waitf(input logic [7:0] m);
    logic [7:0] d;
    int k;
    k = 0;
    d = 8'h00;
    while ((d & m) !== m && k < 100) begin
      rd(sc_o, d);
      k++;
    end
    chk(d & m, m);
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    err_count++;
    end_sim();
  end

  initial begin
    bus_req = '0;
    dsm = 1'b0;
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rc(pc_o, 8'h00);
    rc(sc_o, 8'h00);
    rc(ie_o, 8'h00);
    wr(pc_o, 8'hFF);
    rc(pc_o, 8'hDF);
    wr(pc_o, 8'h00);
    rc(8'h10, 8'h00);
    wr(sc_o, 8'hFF, 8'h08);
    rc(sc_o, 8'h08);
    $display("test registers done");

    wr(sc_o, 8'h40);
    wr(mk_o, 8'h07);
    wr(ie_o, 8'h10);
    fork
      i_remote.grab(9, w, b);
      wr(sd_o, 8'hA5);
    join
    @(posedge clk);
    chk(16'(w), 16'h0004);
    chk(b, 10'h1A5);
    rc(sc_o, 8'h42);
    rc(st_o, 8'h01);
    chk(irq, 1'b0);
    wr(ie_o, 8'h90);
    chk(irq, 1'b1);
    wr(mk_o, 8'h00);
    chk(irq, 1'b0);
    wr(mk_o, 8'h07);
    wr(st_o, 8'h01);
    chk(irq, 1'b0);
    rc(sc_o, 8'h42);
    $display("test transmit and interrupt done");

    for (int i = 0; i < 4; i++) begin
      wr(sc_o, tab[i][0]);
      wr(pc_o, tab[i][1]);
      dsm <= tab[i][2][0];
      fork
        i_remote.grab(10, w, b);
        wr(sd_o, 8'h81);
      join
      chk(16'(w), tab[i][3]);
      chk(b, 10'h381);
      repeat (tab[i][3]) @(posedge clk);
    end
    wr(pc_o, 8'h00);
    dsm <= 1'b0;
    $display("test rates done");

    wr(st_o, 8'h07);
    wr(sc_o, 8'h50);
    i_remote.send(9'h03C, 8, 1'b1, 4);
    rc(sd_o, 8'h3C);
    rc(sc_o, 8'h55);
    i_remote.send(9'h011, 8, 1'b1, 4);
    rc(sd_o, 8'h3C);
    wr(sc_o, 8'h00, 8'h01);
    rc(sc_o, 8'h54);
    $display("test receive done");

    wr(pc_o, 8'h40);
    i_remote.send(9'h00F, 8, 1'b0, 4);
    rc(sc_o, 8'hD1);
    rc(st_o, 8'h06);
    wr(sc_o, 8'h00, 8'h01);
    i_remote.send(9'h00F, 8, 1'b1, 4);
    rc(sc_o, 8'hD5);
    wr(pc_o, 8'h00);
    rc(sc_o, 8'h55);
    wr(pc_o, 8'h40);
    wr(sc_o, 8'h00, 8'h80);
    rc(sc_o, 8'h55);
    wr(sc_o, 8'h00, 8'h11);
    i_remote.send(9'h077, 8, 1'b1, 4);
    rc(sc_o, 8'h44);
    wr(pc_o, 8'h00);
    $display("test framing done");

    wr(sc_o, 8'hF0);
    i_remote.send(9'h022, 9, 1'b1, 4);
    rc(sc_o, 8'hF0);
    i_remote.send(9'h1AA, 9, 1'b1, 4);
    rc(sc_o, 8'hF5);
    rc(sd_o, 8'hAA);
    $display("test multiprocessor done");

    wr(sc_o, 8'h00);
    wr(sd_o, 8'h5A);
    waitf(8'h02);
    chk(oe_seen, 1'b1);
    chk(sh0, 8'h5A);
    wr(sc_o, 8'h10);
    waitf(8'h01);
    rc(sd_o, 8'hFF);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rc(sc_o, 8'h00);
    $display("test shift mode done");
    end_sim();
  end
endmodule
